/* core/dscp_map.vh */
// Register offsets, field positions, reset values and timing counts for the display config bank
`ifndef DSCP_MAP_VH
`define DSCP_MAP_VH
// Register byte offsets (index); byte address is four times the index
`define DSCP_IDX_LCMP_LO     8'h0e
`define DSCP_IDX_LCMP_HI     8'h0f
`define DSCP_IDX_S1_LO       8'h10
`define DSCP_IDX_S1_MID      8'h11
`define DSCP_IDX_S1_HI       8'h12
`define DSCP_IDX_S2_LO       8'h13
`define DSCP_IDX_S2_MID      8'h14
`define DSCP_IDX_S2_HI       8'h15
`define DSCP_IDX_OFS_LO      8'h16
`define DSCP_IDX_OFS_HI      8'h17
`define DSCP_IDX_PAN         8'h18
`define DSCP_IDX_CLK         8'h19
`define DSCP_IDX_PWR         8'h1a
`define DSCP_IDX_MISC        8'h1b
`define DSCP_IDX_STRAP_LO    8'h1c
`define DSCP_IDX_STRAP_HI    8'h1d
`define DSCP_IDX_IODIR       8'h1e
`define DSCP_IDX_MODE        8'h40
`define DSCP_IDX_STAT        8'h41
// Field positions
`define DSCP_CLK_MDIV_BIT    2
`define DSCP_PWR_STAT_BIT    7
`define DSCP_PWR_PDIS_BIT    3
`define DSCP_PWR_SUSP_BIT    0
`define DSCP_MISC_HIDIS_BIT  7
`define DSCP_MISC_HFB_BIT    0
`define DSCP_STRAP_POL_BIT   10
`define DSCP_STRAP_DRAM_LSB  6
// Reset values
`define DSCP_RST_LCMP        10'h3ff
`define DSCP_RST_MISC        8'h80
`define DSCP_RST_ZERO        8'h00
// Suspend refresh encodings
`define DSCP_REF_CBR         2'h0
`define DSCP_REF_SELF        2'h1
// Bus read latency in cycles
`define DSCP_RD_WAIT         1
`endif

/* core/dscp_clk_div.v */
// Programmable clock-enable divider producing a one-cycle pulse every N+1 input enables
`timescale 1ns/100ps
module dscp_clk_div #(
    parameter W = 2                   // Width of divide select
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst,
    // Control
    input  wire         en_in,        // Source rate enable
    input  wire [W-1:0] ratio_m1,     // Divide ratio minus one
    // Result
    output reg          en_out        // One-cycle pulse at divided rate
);

    reg [W-1:0] cnt_r;                // Source enables counted

    ////////////////////////////////////////////////////////////////////////
    // Count source enables; terminal count fires the output pulse
    always @(posedge clk) begin
        if (rst) begin
            cnt_r  <= {W{1'b0}};
            en_out <= 1'b0;
        end else begin
            en_out <= 1'b0;
            if (en_in) begin
                // Ratio shrink mid-count wraps at once, no long gap
                if (cnt_r >= ratio_m1) begin
                    cnt_r  <= {W{1'b0}};
                    en_out <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end
        end
    end
endmodule

/* core/dscp_regs.v */
// Display split-screen, clock and power configuration register bank
// Overview of operation
// R01: Upper screen height is line compare plus one
// R02: Lines below upper screen show screen two
// R03: Host sets compare high to disable split
// R04: Screen one start is 20-bit word address
// R05: Screen two has own 20-bit start address
// R06: Start address plus pan picks first pixel
// R07: One 11-bit line offset serves both screens
// R08: Offset above width gives virtual image window
// R09: Each screen pans by its own nibble
// R10: Only pan bits valid for depth used
// R11: Memory clock halves when divide bit set
// R12: Pixel clock ratio 1:1 to 4:1 select
// R13: Power-save flag: panel off and low refresh
// R14: Panel power disable forces output off
// R15: Strap at reset release sets off level
// R16: Suspend refresh field: cbr, self, none
// R17: Host keeps refresh field during suspend
// R18: Suspend enable bit enters suspend mode
// R19: Host interface disabled at reset; limits access
// R20: Half frame buffer off by bit or single
// R21: Host picks alternate modulation when buffer off
// R22: Sixteen straps latched, read as two bytes
// R23: Upper address pins: address or io by strap
// R24: Io direction bit one makes pin output
// R25: Byte registers, lsb first, unused read zero
`timescale 1ns/100ps
`include "dscp_map.vh"
module dscp_regs #(
    parameter LC_W  = 10,             // Line compare width
    parameter SA_W  = 20,             // Start address width
    parameter OFS_W = 11              // Line offset width
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst,
    // Avalon-MM slave
    input  wire [9:0]       avs_address,
    input  wire             avs_read,
    input  wire             avs_write,
    input  wire [31:0]      avs_writedata,
    input  wire [3:0]       avs_byteenable,
    output reg  [31:0]      avs_readdata,
    output reg              avs_waitrequest,
    // Straps and display context
    input  wire [15:0]      config_strap_pins,
    input  wire [2:0]       bpp_sel,       // Colour depth code
    input  wire             dual_panel,    // Dual panel selected
    input  wire [LC_W-1:0]  line_count,    // Current display line
    input  wire             panel_seq_on,  // Sequencer panel request
    input  wire             panel_is_off,  // Sequencer reports panel down
    input  wire             mem_low_refresh, // Self or cbr-only refresh
    // Upper address pins
    input  wire [2:0]       ma_hi_addr,    // DRAM address bits 11..9
    input  wire [2:0]       io_pin_in,
    input  wire [2:0]       io_pin_out_val,
    output reg  [2:0]       io_pin_out,
    output reg  [2:0]       io_pin_oe,
    output reg  [2:0]       io_pin_status,
    // Display engine settings
    output reg              screen2_active,
    output reg  [SA_W-1:0]  screen1_start_addr,
    output reg  [SA_W-1:0]  screen2_start_addr,
    output reg  [OFS_W-1:0] line_offset_words,
    output reg  [3:0]       pan_pixels,
    output reg              virtual_image,
    // Clocks, power and misc
    output reg              mclk_en,
    output reg              pclk_en,
    output reg              panel_power_out,
    output reg  [1:0]       suspend_refresh,
    output reg              suspend_active,
    output reg              half_frame_buf_en,
    output reg              host_if_enabled
);

    // Panel width in words, compared against the line offset
    localparam [OFS_W-1:0] DISP_W_WORDS = 11'd320;
    localparam [1:0] BS_IDLE = 2'h0;   // Waiting for request
    localparam [1:0] BS_WAIT = 2'h1;   // Read data being formed
    localparam [1:0] BS_DONE = 2'h2;   // Answer cycle

    ////////////////////////////////////////////////////////////////////////
    // Register storage
    reg [LC_W-1:0]  lcmp_r;            // Line compare
    reg [SA_W-1:0]  s1_r;              // Screen one start
    reg [SA_W-1:0]  s2_r;              // Screen two start
    reg [OFS_W-1:0] ofs_r;             // Line offset
    reg [7:0]       pan_r;             // Pan nibbles
    reg [2:0]       clk_r;             // Clock divide bits
    reg [3:0]       pwr_r;             // Power control bits 3..0
    reg             hidis_r;           // Host interface disable
    reg             hfb_dis_r;         // Half frame buffer disable
    reg [2:0]       iodir_r;           // Io directions
    reg [15:0]      strap_r;           // Latched straps
    reg             rst_d_r;           // Reset delayed, for release edge
    reg [1:0]       bs_r;              // Bus state
    reg [1:0]       bs_nxt;
    reg [7:0]       rd_byte_r;         // Pending read byte
    reg             src_tgl_r;         // Memory clock half-rate toggle

    wire [7:0] misc_rst_val = `DSCP_RST_MISC; // Misc reset byte, host disable set
    wire [7:0] idx   = avs_address[9:2];
    wire       acc   = avs_read | avs_write;
    wire       wr_ok = avs_write & avs_byteenable[0] & (bs_r == BS_IDLE) & allowed(idx);

    ////////////////////////////////////////////////////////////////////////
    // Gate accesses while host interface is disabled
    function allowed;
        input [7:0] a;
        begin
            allowed = ~hidis_r | (a == `DSCP_IDX_MISC) | (a == `DSCP_IDX_PWR); // R19
        end
    endfunction

    // Mask pan value to bits valid at this depth
    function [3:0] pan_mask;
        input [3:0] p;
        input [2:0] d;
        begin
            case (d) // R10
                3'h0:    pan_mask = p;
                3'h1:    pan_mask = {1'b0, p[2:0]};
                3'h2:    pan_mask = {2'b0, p[1:0]};
                3'h3:    pan_mask = {3'b0, p[0]};
                default: pan_mask = 4'h0;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus state machine: one wait cycle then answer
    always @* begin
        case (bs_r)
            BS_IDLE: bs_nxt = acc ? BS_WAIT : BS_IDLE;
            BS_WAIT: bs_nxt = BS_DONE;
            BS_DONE: bs_nxt = BS_IDLE;
            default: bs_nxt = BS_IDLE;
        endcase
    end

    // Read mux for the addressed byte
    reg [7:0] rd_mux;
    wire      pwr_stat = panel_is_off & mem_low_refresh; // R13
    always @* begin
        rd_mux = 8'h00; // R25
        if (allowed(idx)) begin
            case (idx)
                `DSCP_IDX_LCMP_LO:  rd_mux = lcmp_r[7:0];
                `DSCP_IDX_LCMP_HI:  rd_mux = {6'h0, lcmp_r[9:8]};
                `DSCP_IDX_S1_LO:    rd_mux = s1_r[7:0];
                `DSCP_IDX_S1_MID:   rd_mux = s1_r[15:8];
                `DSCP_IDX_S1_HI:    rd_mux = {4'h0, s1_r[19:16]};
                `DSCP_IDX_S2_LO:    rd_mux = s2_r[7:0];
                `DSCP_IDX_S2_MID:   rd_mux = s2_r[15:8];
                `DSCP_IDX_S2_HI:    rd_mux = {4'h0, s2_r[19:16]};
                `DSCP_IDX_OFS_LO:   rd_mux = ofs_r[7:0];
                `DSCP_IDX_OFS_HI:   rd_mux = {5'h0, ofs_r[10:8]};
                `DSCP_IDX_PAN:      rd_mux = pan_r;
                `DSCP_IDX_CLK:      rd_mux = {5'h0, clk_r};
                `DSCP_IDX_PWR:      rd_mux = {pwr_stat, 3'h0, pwr_r};
                `DSCP_IDX_MISC:     rd_mux = {hidis_r, 6'h0, hfb_dis_r};
                `DSCP_IDX_STRAP_LO: rd_mux = strap_r[7:0]; // R22
                `DSCP_IDX_STRAP_HI: rd_mux = strap_r[15:8];
                `DSCP_IDX_IODIR:    rd_mux = {4'h0, iodir_r, 1'b0};
                `DSCP_IDX_MODE:     rd_mux = {5'h0, bpp_sel};
                `DSCP_IDX_STAT:     rd_mux = {6'h0, screen2_active, suspend_active};
                default:            rd_mux = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake and read data; waitrequest low only in answer cycle
    always @(posedge clk) begin
        if (rst) begin
            bs_r            <= BS_IDLE;
            rd_byte_r       <= `DSCP_RST_ZERO;
            avs_readdata    <= 32'h0000_0000;
            avs_waitrequest <= 1'b1;
        end else begin
            bs_r            <= bs_nxt;
            avs_waitrequest <= ~(bs_nxt == BS_DONE);
            if (bs_r == BS_IDLE)
                rd_byte_r <= rd_mux;
            if (bs_nxt == BS_DONE)
                avs_readdata <= {24'h000000, rd_byte_r};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes, taken in the request's first cycle
    always @(posedge clk) begin
        if (rst) begin
            lcmp_r    <= `DSCP_RST_LCMP; // R03
            s1_r      <= {SA_W{1'b0}};
            s2_r      <= {SA_W{1'b0}};
            ofs_r     <= {OFS_W{1'b0}};
            pan_r     <= `DSCP_RST_ZERO;
            clk_r     <= 3'h0;
            pwr_r     <= 4'h0;
            hidis_r   <= misc_rst_val[`DSCP_MISC_HIDIS_BIT]; // R19
            hfb_dis_r <= 1'b0;
            iodir_r   <= 3'h0; // R24
        end else if (wr_ok) begin
            case (idx)
                `DSCP_IDX_LCMP_LO: lcmp_r[7:0]   <= avs_writedata[7:0];
                `DSCP_IDX_LCMP_HI: lcmp_r[9:8]   <= avs_writedata[1:0];
                `DSCP_IDX_S1_LO:   s1_r[7:0]     <= avs_writedata[7:0]; // R04
                `DSCP_IDX_S1_MID:  s1_r[15:8]    <= avs_writedata[7:0];
                `DSCP_IDX_S1_HI:   s1_r[19:16]   <= avs_writedata[3:0];
                `DSCP_IDX_S2_LO:   s2_r[7:0]     <= avs_writedata[7:0]; // R05
                `DSCP_IDX_S2_MID:  s2_r[15:8]    <= avs_writedata[7:0];
                `DSCP_IDX_S2_HI:   s2_r[19:16]   <= avs_writedata[3:0];
                `DSCP_IDX_OFS_LO:  ofs_r[7:0]    <= avs_writedata[7:0]; // R25
                `DSCP_IDX_OFS_HI:  ofs_r[10:8]   <= avs_writedata[2:0];
                `DSCP_IDX_PAN:     pan_r         <= avs_writedata[7:0];
                `DSCP_IDX_CLK:     clk_r         <= avs_writedata[2:0];
                `DSCP_IDX_PWR:     pwr_r         <= avs_writedata[3:0]; // R16
                `DSCP_IDX_MISC: begin
                    hidis_r   <= avs_writedata[`DSCP_MISC_HIDIS_BIT];
                    hfb_dis_r <= avs_writedata[`DSCP_MISC_HFB_BIT];
                end
                `DSCP_IDX_IODIR:   iodir_r       <= avs_writedata[3:1];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Strap capture on the clock edge after reset release
    always @(posedge clk) begin
        rst_d_r <= rst;
        if (rst_d_r & ~rst)
            strap_r <= config_strap_pins; // R22
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock enables: memory rate, then pixel ratio divider
    wire mclk_nxt = clk_r[`DSCP_CLK_MDIV_BIT] ? src_tgl_r : 1'b1; // R11
    wire pclk_raw;
    always @(posedge clk) begin
        if (rst) begin
            src_tgl_r <= 1'b0;
            mclk_en   <= 1'b0;
        end else begin
            src_tgl_r <= ~src_tgl_r;
            mclk_en   <= mclk_nxt;
        end
    end

    dscp_clk_div #(.W(2)) u_pdiv (
        .clk      (clk),
        .rst      (rst),
        .en_in    (mclk_nxt),
        .ratio_m1 (clk_r[1:0]),     // R12
        .en_out   (pclk_raw)
    );

    ////////////////////////////////////////////////////////////////////////
    // Display, power and pin outputs, all registered
    wire [2:0] ma_is_addr = (strap_r[7:6] == 2'h3) ? 3'h7 :
                            (strap_r[7:6] == 2'h0) ? 3'h0 : 3'h1; // R23
    wire [LC_W:0] s1_height = {1'b0, lcmp_r} + 1'b1; // R01
    wire          in_s2 = {1'b0, line_count} >= s1_height; // R02
    wire          pol   = strap_r[`DSCP_STRAP_POL_BIT]; // R15
    // Direction bits 3,1,2 serve pins a,b,c; pin a doubles as the third io
    wire [2:0]    pin_dir = {iodir_r[1], iodir_r[0], iodir_r[2]}; // R24
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_io
            always @(posedge clk) begin
                if (rst) begin
                    io_pin_out[g]    <= 1'b0;
                    io_pin_oe[g]     <= 1'b0;
                    io_pin_status[g] <= 1'b0;
                end else begin
                    // Address function overrides direction bit
                    io_pin_out[g]    <= ma_is_addr[g] ? ma_hi_addr[g] : io_pin_out_val[g];
                    io_pin_oe[g]     <= ma_is_addr[g] | pin_dir[g]; // R24
                    io_pin_status[g] <= io_pin_in[g];
                end
            end
        end
    endgenerate

    always @(posedge clk) begin
        if (rst) begin
            screen2_active     <= 1'b0;
            screen1_start_addr <= {SA_W{1'b0}};
            screen2_start_addr <= {SA_W{1'b0}};
            line_offset_words  <= {OFS_W{1'b0}};
            pan_pixels         <= 4'h0;
            virtual_image      <= 1'b0;
            pclk_en            <= 1'b0;
            panel_power_out    <= 1'b0;
            suspend_refresh    <= `DSCP_REF_CBR;
            suspend_active     <= 1'b0;
            half_frame_buf_en  <= 1'b0;
            host_if_enabled    <= 1'b0;
        end else begin
            screen2_active     <= in_s2; // R02
            screen1_start_addr <= s1_r; // R06
            screen2_start_addr <= s2_r;
            line_offset_words  <= ofs_r; // R07
            // Pan nibble chosen by screen region
            pan_pixels         <= pan_mask(in_s2 ? pan_r[7:4] : pan_r[3:0], bpp_sel); // R09
            virtual_image      <= ofs_r > DISP_W_WORDS; // R08
            pclk_en            <= pclk_raw;
            // Forced off uses strap off level, else sequencer
            panel_power_out    <= pwr_r[`DSCP_PWR_PDIS_BIT] ? pol : (panel_seq_on ^ pol); // R14
            suspend_refresh    <= pwr_r[2:1]; // R16
            suspend_active     <= pwr_r[`DSCP_PWR_SUSP_BIT]; // R18
            half_frame_buf_en  <= dual_panel & ~hfb_dis_r; // R20
            host_if_enabled    <= ~hidis_r; // R19
        end
    end
endmodule

/* verification/dscp_host.sv */
// Host bus master model issuing one register cycle at a time
`timescale 1ns/100ps
module dscp_host (
    // Clock
    input  logic        clk,
    // Slave answer
    input  logic [31:0] avs_readdata,
    input  logic        avs_waitrequest,
    // Master request
    output logic [9:0]  avs_address,
    output logic        avs_read,
    output logic        avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0]  avs_byteenable,
    output logic        hung
);
    ////////////////////////////////////////////////////////////////////////
    // Idle bus at time zero
    initial begin
        {avs_read, avs_write, hung} = 3'h0;
        avs_address = 10'h3ff;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
    end
    // One transfer; request held until waitrequest is sampled low
    task xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        int n;
        @(posedge clk);
        avs_address <= {idx, 2'h0};
        avs_writedata <= {24'h0, wd};
        avs_byteenable <= 4'h1;
        avs_read <= !wr;
        avs_write <= wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata[7:0];
        if (n >= 20) hung = 1'b1;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // Released lines carry no stale value
        avs_address <= ~avs_address;
        avs_writedata <= ~avs_writedata;
    endtask
endmodule

/* verification/dscp_regs_props.sv */
// Port assertions for the display configuration register bank
`timescale 1ns/100ps
module dscp_regs_props (
    // Clock and reset
    input logic        clk,
    input logic        rst,
    // Bus
    input logic [9:0]  avs_address,
    input logic        avs_read,
    input logic        avs_write,
    input logic [31:0] avs_readdata,
    input logic        avs_waitrequest,
    // Context and settings
    input logic [2:0]  bpp_sel,
    input logic        dual_panel,
    input logic [3:0]  pan_pixels,
    input logic        mclk_en,
    input logic        half_frame_buf_en,
    input logic        host_if_enabled
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    a_read_upper_zero: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("readdata upper bits not zero");
    a_answer_latency: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##2 !avs_waitrequest)
        else $error("answer not two cycles after take");
    a_answer_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_blocked_read_zero: assert property ((avs_read && !avs_waitrequest && !host_if_enabled
        && avs_address[9:2] != 8'h1a && avs_address[9:2] != 8'h1b) |-> avs_readdata == 32'h0)
        else $error("blocked read returned data");
    a_host_off_reset: assert property ($fell(rst) |-> !host_if_enabled ##1 !host_if_enabled)
        else $error("host interface enabled after reset");
    a_hfb_single_off: assert property ((!dual_panel && !$past(dual_panel)) |-> !half_frame_buf_en)
        else $error("half frame buffer on with single panel");
    a_mclk_no_gap: assert property ((!mclk_en && !$past(rst) && !$past(rst, 2)) |=> mclk_en)
        else $error("memory clock enable slower than half rate");
    a_pan_depth_mask: assert property ((bpp_sel == $past(bpp_sel) && bpp_sel == $past(bpp_sel, 2)
        && bpp_sel <= 3'h5) |-> (pan_pixels & ~(4'hf >> bpp_sel)) == 4'h0)
        else $error("pan uses bits invalid for depth");
endmodule
bind dscp_regs dscp_regs_props u_props (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .bpp_sel, .dual_panel, .pan_pixels, .mclk_en, .half_frame_buf_en, .host_if_enabled);

/* verification/dscp_regs_test.sv */
// Self-checking bench for the display configuration register bank
`timescale 1ns/100ps
module dscp_regs_test;
    logic        clk, rst;                   // Clock and reset
    logic [9:0]  avs_address;                // Bus driven by host model
    logic        avs_read, avs_write, hung;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable;
    logic        avs_waitrequest;
    logic [15:0] strap, st;                  // Strap pins and latched copy
    logic [2:0]  bpp_sel, ma_hi, io_in, io_val, io_out, io_oe, io_st;
    logic        dual, seq_on, is_off, low_ref, s2act, mclk_en, pclk_en, ppow, susp, hfb, hen, vimg;
    logic [9:0]  line_count;
    logic [19:0] s1, s2;
    logic [10:0] ofs;
    logic [3:0]  pan;
    logic [1:0]  sref;
    logic [7:0]  rd, v;
    logic [7:0]  e [256];                    // Expected register contents
    logic [7:0]  idx [12] = '{8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1e};
    logic [7:0]  msk [12] = '{8'hff, 8'h03, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'h0f, 8'hff, 8'h07, 8'hff, 8'h0e};
    int          errors, checks, m, p, em;

    dscp_host host (.clk, .avs_readdata, .avs_waitrequest, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .hung);
    dscp_regs DUT (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .config_strap_pins(strap),
        .bpp_sel(bpp_sel), .dual_panel(dual), .line_count(line_count), .panel_seq_on(seq_on),
        .panel_is_off(is_off), .mem_low_refresh(low_ref), .ma_hi_addr(ma_hi), .io_pin_in(io_in),
        .io_pin_out_val(io_val), .io_pin_out(io_out), .io_pin_oe(io_oe), .io_pin_status(io_st),
        .screen2_active(s2act), .screen1_start_addr(s1), .screen2_start_addr(s2), .line_offset_words(ofs),
        .pan_pixels(pan), .virtual_image(vimg), .mclk_en(mclk_en), .pclk_en(pclk_en), .panel_power_out(ppow),
        .suspend_refresh(sref), .suspend_active(susp), .half_frame_buf_en(hfb), .host_if_enabled(hen));

    ////////////////////////////////////////////////////////////////////////
    // Compare and count
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Verdict and end of run
    task results;
        if (errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task wr(input logic [7:0] i, input logic [7:0] d);
        host.xfer(1'b1, i, d, rd);
    endtask
    task rchk(input string what, input logic [7:0] i, input logic [7:0] x);
        host.xfer(1'b0, i, 8'h0, rd);
        chk(what, 32'(rd), 32'(x));
    endtask
    // Pin a is an address output unless all three are io; all three for type 3
    function logic pin_addr(input logic [1:0] t, input int i);
        return t == 2'h3 || (t != 2'h0 && i == 0);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Watchdog: the full run needs well under 50000 cycles
    initial begin
        #400000;
        errors++;
        results;
    end
    initial begin
        {rst, dual, seq_on, is_off, low_ref} = 5'h10;
        {bpp_sel, ma_hi, io_in, io_val} = 12'h0;
        line_count = 10'h0;
        strap = 16'h0;
        errors = 0;
        checks = 0;
        void'($urandom(32'h4a44));
        // Each pass resets with a different memory type strap
        for (int t = 0; t < 4; t++) begin
            @(posedge clk);
            rst <= 1'b1;
            strap <= (16'($urandom) & 16'hff3f) | 16'(t << 6);
            repeat (5) @(posedge clk);
            rst <= 1'b0;
            @(posedge clk);
            st = strap;
            strap <= ~strap;                                    // Latch must not follow pins
            chk("host_en", 32'(hen), 32'h0);
            is_off <= 1'b1;
            low_ref <= 1'(t);
            rchk("pwr_blk", 8'h1a, {1'(t), 7'h0});
            rchk("misc_rst", 8'h1b, 8'h80);
            wr(8'h10, 8'h5a);
            chk("s1_blk", 32'(s1), 32'h0);
            rchk("blk_rd", 8'h0e, 8'h00);
            wr(8'h1b, 8'h00);
            chk("host_en", 32'(hen), 32'h1);
            rchk("lc_lo", 8'h0e, 8'hff);
            rchk("lc_hi", 8'h0f, 8'h03);
            foreach (idx[k]) begin
                v = 8'($urandom) & 8'hfd;
                wr(idx[k], v);
                e[idx[k]] = v & msk[k];
            end
            foreach (idx[k]) rchk("rw", idx[k], e[idx[k]]);
            chk("s1", 32'(s1), 32'({e[8'h12][3:0], e[8'h11], e[8'h10]}));
            chk("s2", 32'(s2), 32'({e[8'h15][3:0], e[8'h14], e[8'h13]}));
            chk("ofs", 32'(ofs), 32'({e[8'h17][2:0], e[8'h16]}));
            chk("virt", 32'(vimg), 32'({e[8'h17][2:0], e[8'h16]} > 11'd320));
            // Last upper line, then first lower line, each depth
            for (int d = 0; d < 2; d++) begin
                line_count <= {e[8'h0f][1:0], e[8'h0e]} + 10'(d);
                for (int b = 0; b < 6; b++) begin
                    bpp_sel <= 3'(b);
                    repeat (3) @(posedge clk);
                    chk("split", 32'(s2act), 32'(d));
                    chk("pan", 32'(pan), 32'((d ? e[8'h18][7:4] : e[8'h18][3:0]) & (4'hf >> b)));
                end
            end
            // Enable rates over 240 cycles per clock setting
            for (int c = 0; c < 8; c++) begin
                wr(8'h19, 8'(c));
                m = 0;
                p = 0;
                repeat (240) begin
                    @(posedge clk);
                    m += 32'(mclk_en);
                    p += 32'(pclk_en);
                end
                em = c[2] ? 120 : 240;
                chk("mclk", 32'(m >= em - 1 && m <= em + 1), 32'h1);
                em = em / (c % 4 + 1);
                chk("pclk", 32'(p >= em - 1 && p <= em + 1), 32'h1);
            end
            e[8'h1a] = 8'h00;
            for (int k = 0; k < 16; k++) begin
                v = 8'(k);
                {seq_on, is_off, low_ref} <= 3'($urandom);
                wr(8'h1a, e[8'h1a] & 8'h0e);
                wr(8'h1a, v & 8'h0e);
                wr(8'h1a, v);
                e[8'h1a] = v;
                rchk("pwr", 8'h1a, v | {is_off & low_ref, 7'h0});
                chk("sref", 32'(sref), 32'(v[2:1]));
                chk("susp", 32'(susp), 32'(v[0]));
                chk("ppow", 32'(ppow), 32'(st[10] ^ (!v[3] & seq_on)));
            end
            for (int k = 0; k < 4; k++) begin
                dual <= k[1];
                wr(8'h1b, 8'(k[0]));
                chk("hfb", 32'(hfb), 32'(k[1] & !k[0]));
            end
            v = 8'($urandom);
            wr(8'h1e, v);
            {ma_hi, io_val, io_in} <= 9'($urandom);
            repeat (3) @(posedge clk);
            for (int i = 0; i < 3; i++) begin
                chk("oe", 32'(io_oe[i]), 32'(pin_addr(2'(t), i) | v[i ? i : 3]));
                chk("stat", 32'(io_st[i]), 32'(io_in[i]));
                if (io_oe[i] === 1'b1) chk("out", 32'(io_out[i]), 32'(pin_addr(2'(t), i) ? ma_hi[i] : io_val[i]));
            end
            rchk("unmap", 8'h30, 8'h00);
            wr(8'h1c, 8'ha5);
            rchk("strap_lo", 8'h1c, st[7:0]);
            rchk("strap_hi", 8'h1d, st[15:8]);
        end
        chk("hung", 32'(hung), 32'h0);
        results;
    end
endmodule
